// [pkg/ccs_pkg.sv]
// ==========================================================
// Clock speed control constants
package ccs_pkg;

  // ========================================================
  // Special function register map
  localparam logic [7:0] SFR_CLOCK_SPEED_CONTROL = 8'h8f;
  localparam logic [7:0] CLOCK_SPEED_RESET       = 8'h00;

  // ========================================================
  // Field positions inside clock_speed_control
  localparam int BIT_CAN_SPEED_SEL           = 7;
  localparam int BIT_WATCHDOG_SPEED_SEL      = 6;
  localparam int BIT_COUNTER_ARRAY_SPEED_SEL = 5;
  localparam int BIT_UART_SPEED_SEL          = 4;
  localparam int BIT_TIMER2_SPEED_SEL        = 3;
  localparam int BIT_TIMER1_SPEED_SEL        = 2;
  localparam int BIT_TIMER0_SPEED_SEL        = 1;
  localparam int BIT_CPU_DOUBLE_SPEED        = 0;

  // ========================================================
  // Cycle generator slots: slot 0 is the CPU, slot n is bit n
  localparam int NUM_SLOTS = 8;

  // ========================================================
  // Timing
  localparam int CLK_PERIOD_NS         = 40;
  localparam int OSC_PER_CYCLE_STD     = 12;
  localparam int OSC_PER_CYCLE_X2      = 6;
  localparam int TICKS_PER_CYCLE       = OSC_PER_CYCLE_X2;
  localparam int TICK_CNT_W            = 3;
  localparam logic [2:0] TICK_LAST     = 3'(TICKS_PER_CYCLE - 1);
  // CLK is the oscillator itself: one period per clock cycle
  localparam int OSC_PER_CLK           = 1;
  localparam int WARM_RST_MIN_OSC      = 24;
  localparam int WARM_RST_MIN_CYC      = WARM_RST_MIN_OSC * OSC_PER_CLK;

  // ========================================================
  // UART modes in which the UART speed bit acts
  localparam logic [1:0] UART_MODE_SYNC  = 2'h0;
  localparam logic [1:0] UART_MODE_FIXED = 2'h2;

  // ========================================================
  // Internal warm reset sources
  localparam int NUM_INT_RST = 3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ccs_sfr_req_s;

endpackage : ccs_pkg

// [design/ccs_cycle_gen.sv]
`timescale 1ns/1ps
// ==========================================================
// Machine or peripheral cycle generator
module ccs_cycle_gen #(
  parameter int CNT_W = ccs_pkg::TICK_CNT_W
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             fast,
  input  wire logic             div_rise,
  input  wire logic [CNT_W-1:0] last,
  output logic                  stb_r,
  output logic                  fast_r
);

  logic             tick;
  logic [CNT_W-1:0] cnt_r;

  // Fast rate bypasses the divide-by-two, slow waits for its edge
  assign tick = fast | div_rise;

  // ========================================================
  // Tick counter, six ticks to a cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (tick) begin
      cnt_r <= (cnt_r == last) ? '0 : cnt_r + 1'b1;
    end
  end

  // One-clock strobe at the end of each cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stb_r <= 1'b0;
    end else begin
      stb_r <= tick & (cnt_r == last);
    end
  end

  // Rate in force, visible for status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_r <= 1'b0;
    end else begin
      fast_r <= fast;
    end
  end

endmodule : ccs_cycle_gen

// [design/ccs_rst_ctrl.sv]
`timescale 1ns/1ps
// ==========================================================
// Warm and cold reset combiner
module ccs_rst_ctrl #(
  parameter int NSRC    = ccs_pkg::NUM_INT_RST,
  parameter int STRETCH = ccs_pkg::WARM_RST_MIN_CYC
) (
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic            rst_pin,
  input  wire logic [NSRC-1:0] int_req,
  output logic                 sys_rst_r,
  output logic [NSRC:0]        cause_r
);

  localparam logic [4:0] STRETCH_L = 5'(STRETCH);

  logic [4:0] stretch_r;
  logic       any_int;

  assign any_int = |int_req;

  // ========================================================
  // Internal pulses are stretched to a full valid warm reset,
  // since the requester may only pulse for one clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stretch_r <= '0;
    end else if (any_int) begin
      stretch_r <= STRETCH_L; // R11
    end else if (stretch_r != 5'h00) begin
      stretch_r <= stretch_r - 5'h01;
    end
  end

  // Reset level follows the pin for as long as it is held
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_rst_r <= 1'b1;
    end else begin
      sys_rst_r <= rst_pin | any_int | (stretch_r != 5'h00); // R10 R11
    end
  end

  // Last cause: bit 0 pin, bits above the internal sources
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cause_r <= '0;
    end else if (rst_pin | any_int) begin
      cause_r <= {int_req, rst_pin};
    end
  end

endmodule : ccs_rst_ctrl

// [design/ccs_clock_speed_ctrl.sv]
`timescale 1ns/1ps
// ==========================================================
// Clock speed control: cycle strobes for CPU and peripherals
//
// How it works
// (R1) Speed register at 8Fh, eight select bits
// (R2) Double-speed clear: everything at twelve periods
// (R3) Double-speed set: CPU six, peripheral bits live
// (R4) Cleared peripheral bit gives six periods
// (R5) Set peripheral bit keeps twelve periods
// (R6) Peripheral bits ignored while double-speed low
// (R7) UART bit only in modes 0, 2
// (R8) Counter array bit selects its rate
// (R9) Register resets to all zeros
// (R10) Reset level initialises registers while held
// (R11) Internal sources also raise warm reset
// (R12) Outside holds reset until supply, oscillator good
// (R13) Speed change taken on divided-clock rising edge
// (R14) Standard divides by two, double bypasses
// (R15) Outside holds reset 24 oscillator periods
// (R16) Register fully readable, returns last write
module ccs_clock_speed_ctrl #(
  parameter int NUM_RST_SRC = ccs_pkg::NUM_INT_RST
) (
  input  wire logic                    CLK,
  input  wire logic                    RST_B,
  input  wire logic                    RST_PIN,
  input  wire logic [NUM_RST_SRC-1:0]  INT_RST_REQ,
  input  wire ccs_pkg::ccs_sfr_req_s   SFR_REQ,
  input  wire logic [1:0]              UART_MODE,
  output logic [7:0]                   SFR_RDATA,
  output logic                         SFR_RVALID,
  output logic                         SYS_RST,
  output logic [NUM_RST_SRC:0]         RST_CAUSE,
  output logic                         CPU_X2_ACTIVE,
  output logic                         DIV2_CLK,
  output logic [ccs_pkg::NUM_SLOTS-1:0] CYCLE_STB,
  output logic [ccs_pkg::NUM_SLOTS-1:0] FAST_RATE
);

  // ========================================================
  // Declarations
  logic [7:0]                    speed_r;
  logic [7:0]                    speed_nxt;
  logic [7:0]                    valid_r;
  logic                          phase_r;
  logic                          div_rise;
  logic                          sys_rst_r;
  logic [ccs_pkg::NUM_SLOTS-1:0] fast_sel;
  logic                          uart_bit_live;
  logic                          wr_hit;
  logic                          rd_hit;
  logic [7:0]                    rdata_r;
  logic                          rvalid_r;

  // ========================================================
  // Decode of the one mapped address, shared by read and write
  function automatic logic sfr_hit(input logic [7:0] addr);
    sfr_hit = (addr == ccs_pkg::SFR_CLOCK_SPEED_CONTROL); // R1
  endfunction : sfr_hit

  assign wr_hit = SFR_REQ.wr & sfr_hit(SFR_REQ.addr);
  assign rd_hit = SFR_REQ.rd & sfr_hit(SFR_REQ.addr);

  // ========================================================
  // Reset combiner
  // Pin held by the outside for a valid warm reset, internal
  // sources stretched to the same minimum
  ccs_rst_ctrl #(
    .NSRC    (NUM_RST_SRC),
    .STRETCH (ccs_pkg::WARM_RST_MIN_CYC) // R15
  ) u_rst (
    .clk       (CLK),
    .rst_b     (RST_B),
    .rst_pin   (RST_PIN),
    .int_req   (INT_RST_REQ),
    .sys_rst_r (sys_rst_r),
    .cause_r   (RST_CAUSE)
  );

  // ========================================================
  // Software register
  // Writes are dropped while reset is asserted, so a boot-time
  // write cannot leave the part in double speed unexpectedly
  always_comb begin
    speed_nxt = speed_r;
    if (sys_rst_r) begin
      speed_nxt = ccs_pkg::CLOCK_SPEED_RESET; // R10
    end else if (wr_hit) begin
      speed_nxt = SFR_REQ.wdata; // R16
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      speed_r <= ccs_pkg::CLOCK_SPEED_RESET; // R9
    end else begin
      speed_r <= speed_nxt;
    end
  end

  // ========================================================
  // Read path, one clock after the request
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rd_hit ? speed_r : 8'h00; // R16
      rvalid_r <= rd_hit;
    end
  end

  assign SFR_RDATA  = rdata_r;
  assign SFR_RVALID = rvalid_r;

  // ========================================================
  // Divide-by-two of the oscillator
  // Rising edge of the divided clock is the clock on which
  // phase goes from low to high
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
    end
  end

  assign div_rise = ~phase_r; // R14
  assign DIV2_CLK = phase_r;

  // ========================================================
  // Validated copy of the register
  // Only takes the register on a divided rising edge: a change mid-phase
  // would otherwise cut a slow tick short and glitch the core
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      valid_r <= ccs_pkg::CLOCK_SPEED_RESET;
    end else if (sys_rst_r) begin
      valid_r <= ccs_pkg::CLOCK_SPEED_RESET;
    end else if (div_rise) begin
      valid_r <= speed_r; // R13
    end
  end

  assign CPU_X2_ACTIVE = valid_r[ccs_pkg::BIT_CPU_DOUBLE_SPEED];

  // ========================================================
  // Rate selection per slot
  // UART bit acts only in its synchronous and fixed-rate modes;
  // in the timer-driven modes it follows the CPU rate
  assign uart_bit_live = (UART_MODE == ccs_pkg::UART_MODE_SYNC) |
                         (UART_MODE == ccs_pkg::UART_MODE_FIXED); // R7

  always_comb begin
    fast_sel = '0;
    // CPU: double speed bypasses the divider, else twelve
    fast_sel[0] = valid_r[ccs_pkg::BIT_CPU_DOUBLE_SPEED]; // R2 R3
    for (int i = 1; i < ccs_pkg::NUM_SLOTS; i++) begin
      // Bit only counts with double speed on; set keeps twelve
      fast_sel[i] = valid_r[ccs_pkg::BIT_CPU_DOUBLE_SPEED] &
                    ~valid_r[i]; // R4 R5 R6 R8
    end
    if (!uart_bit_live) begin
      fast_sel[ccs_pkg::BIT_UART_SPEED_SEL] =
        valid_r[ccs_pkg::BIT_CPU_DOUBLE_SPEED]; // R7
    end
  end

  // ========================================================
  // Cycle generators, one per slot
  // Six ticks per cycle: slow ticks every second oscillator
  // period give twelve, fast ticks every period give six
  genvar g;
  generate
    for (g = 0; g < ccs_pkg::NUM_SLOTS; g++) begin : g_slot
      ccs_cycle_gen #(
        .CNT_W (ccs_pkg::TICK_CNT_W)
      ) u_gen (
        .clk      (CLK),
        .rst_b    (RST_B),
        .fast     (fast_sel[g]),
        .div_rise (div_rise),
        .last     (ccs_pkg::TICK_LAST),
        .stb_r    (CYCLE_STB[g]), // R2 R3 R4 R5 R14
        .fast_r   (FAST_RATE[g])
      );
    end
  endgenerate

  // ========================================================
  // Reset out
  // Peripherals and core see the combined level; generators
  // keep running during reset so clocks are alive at release
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      SYS_RST <= 1'b1;
    end else begin
      SYS_RST <= sys_rst_r; // R10
    end
  end

endmodule : ccs_clock_speed_ctrl

// [tb/ccs_clock_speed_ctrl_assertions.sv]
`timescale 1ns/1ps
// ==========================================================
// Port checks for the clock speed control
module ccs_clock_speed_ctrl_assertions #(
  parameter int NUM_RST_SRC = 3
) (
  input wire logic                     CLK,
  input wire logic                     RST_B,
  input wire logic                     RST_PIN,
  input wire logic [NUM_RST_SRC-1:0]   INT_RST_REQ,
  input wire ccs_pkg::ccs_sfr_req_s    SFR_REQ,
  input wire logic [1:0]               UART_MODE,
  input wire logic [7:0]               SFR_RDATA,
  input wire logic                     SFR_RVALID,
  input wire logic                     SYS_RST,
  input wire logic [NUM_RST_SRC:0]     RST_CAUSE,
  input wire logic                     CPU_X2_ACTIVE,
  input wire logic                     DIV2_CLK,
  input wire logic [7:0]               CYCLE_STB,
  input wire logic [7:0]               FAST_RATE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);

  // Read aimed at the one mapped address
  logic rd_hit;
  assign rd_hit = SFR_REQ.rd && (SFR_REQ.addr == ccs_pkg::SFR_CLOCK_SPEED_CONTROL);

  sequence s_cpu_quiet;
    !CYCLE_STB[0] [*5];
  endsequence
  sequence s_rst_held;
    SYS_RST [*8];
  endsequence

  AST_READ_ANSWER: assert property (rd_hit |=> SFR_RVALID)
    else $error("mapped read gave no valid");
  AST_UNMAPPED_QUIET: assert property (!rd_hit |=> !SFR_RVALID && SFR_RDATA == 8'h00)
    else $error("valid or data without mapped read");
  AST_STD_ALL_SLOW: assert property (!CPU_X2_ACTIVE && !$past(CPU_X2_ACTIVE)
    |-> FAST_RATE == 8'h00)
    else $error("fast slot while double speed off");
  AST_CPU_FAST: assert property (CPU_X2_ACTIVE && $past(CPU_X2_ACTIVE) |-> FAST_RATE[0])
    else $error("cpu slot slow in double speed");
  AST_DIV2_TOGGLE: assert property ($past(RST_B) |-> DIV2_CLK != $past(DIV2_CLK))
    else $error("divided clock failed to toggle");
  // A warm reset clears the copy at once, so only software changes count
  AST_X2_ON_DIV_RISE: assert property ($changed(CPU_X2_ACTIVE) && !SYS_RST
    |-> $rose(DIV2_CLK))
    else $error("speed change off divided rising edge");
  AST_CPU_GAP: assert property (CYCLE_STB[0] |=> s_cpu_quiet)
    else $error("cpu strobes closer than six clocks");
  AST_PIN_RESET: assert property (RST_PIN |-> ##2 SYS_RST)
    else $error("pin reset did not reach reset out");
  AST_INT_RESET: assert property (INT_RST_REQ != '0 |-> ##2 s_rst_held)
    else $error("internal reset not held");
endmodule : ccs_clock_speed_ctrl_assertions

bind ccs_clock_speed_ctrl ccs_clock_speed_ctrl_assertions #(.NUM_RST_SRC(NUM_RST_SRC)) u_chk (
  .CLK(CLK), .RST_B(RST_B), .RST_PIN(RST_PIN), .INT_RST_REQ(INT_RST_REQ), .SFR_REQ(SFR_REQ),
  .UART_MODE(UART_MODE), .SFR_RDATA(SFR_RDATA), .SFR_RVALID(SFR_RVALID), .SYS_RST(SYS_RST),
  .RST_CAUSE(RST_CAUSE), .CPU_X2_ACTIVE(CPU_X2_ACTIVE), .DIV2_CLK(DIV2_CLK),
  .CYCLE_STB(CYCLE_STB), .FAST_RATE(FAST_RATE));

// [tb/testbench.sv]
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the clock speed control
module testbench;
  logic                  clk, rst_b, rst_pin, sfr_rvalid, sys_rst, cpu_x2_active, div2_clk;
  logic [2:0]            int_rst_req;
  logic [1:0]            uart_mode;
  logic [3:0]            rst_cause;
  logic [7:0]            sfr_rdata, cycle_stb, fast_rate;
  ccs_pkg::ccs_sfr_req_s sfr_req;
  int                    error_cnt, cmp_count;

  ccs_clock_speed_ctrl #(.NUM_RST_SRC(3)) uut (
    .CLK(clk), .RST_B(rst_b), .RST_PIN(rst_pin), .INT_RST_REQ(int_rst_req),
    .SFR_REQ(sfr_req), .UART_MODE(uart_mode), .SFR_RDATA(sfr_rdata), .SFR_RVALID(sfr_rvalid),
    .SYS_RST(sys_rst), .RST_CAUSE(rst_cause), .CPU_X2_ACTIVE(cpu_x2_active),
    .DIV2_CLK(div2_clk), .CYCLE_STB(cycle_stb), .FAST_RATE(fast_rate));

  // ========================================================
  // Clock and helpers
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task end_sim;
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // One write; request held for exactly the taking edge
  task wr(input logic [7:0] d);
    @(posedge clk);
    sfr_req <= {ccs_pkg::SFR_CLOCK_SPEED_CONTROL, d, 2'b10};
    @(posedge clk);
    sfr_req <= '0;
  endtask : wr

  // Read, then judge valid and data just after the answer edge
  task rd(input logic [7:0] a, input logic [7:0] e, input logic v);
    @(posedge clk);
    sfr_req <= {a, 8'h00, 2'b01};
    @(posedge clk);
    sfr_req <= '0;
    #1;
    chk({7'h00, sfr_rvalid, sfr_rdata}, {7'h00, v, e});
  endtask : rd

  // Cycles between two strobes of one slot, bounded wait
  task gap(input int s, input int e);
    int n;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (cycle_stb[s] !== 1'b1 && n < 40);
    n = 0;
    do begin @(posedge clk); #1; n++; end while (cycle_stb[s] !== 1'b1 && n < 40);
    chk(16'(n), 16'(e));
  endtask : gap

  // Let validation on the divided clock and the rate flops land
  task settle;
    repeat (4) @(posedge clk);
    #1;
  endtask : settle

  // ========================================================
  // Scenarios
  task t_reset;
    rd(ccs_pkg::SFR_CLOCK_SPEED_CONTROL, 8'h00, 1'b1);
    rd(8'h8e, 8'h00, 1'b0);
    chk({8'h00, fast_rate}, 16'h0000);
    gap(0, 12);
    gap(7, 12);
  endtask : t_reset

  task t_regs;
    logic [7:0] v[4] = '{8'ha5, 8'h5a, 8'h3c, 8'h00};
    foreach (v[i]) begin
      wr(v[i]);
      rd(ccs_pkg::SFR_CLOCK_SPEED_CONTROL, v[i], 1'b1);
    end
  endtask : t_regs

  task t_speeds;
    wr(8'hfe);
    settle;
    chk({7'h00, cpu_x2_active, fast_rate}, 16'h0000);
    gap(1, 12);
    wr(8'h01);
    settle;
    chk({7'h00, cpu_x2_active, fast_rate}, 16'h01ff);
    gap(0, 6);
    gap(5, 6);
    wr(8'he1);
    settle;
    chk({8'h00, fast_rate}, 16'h001f);
    gap(5, 12);
    gap(7, 12);
    gap(1, 6);
  endtask : t_speeds

  task t_uart;
    wr(8'h11);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      uart_mode <= 2'(m);
      settle;
      chk({8'h00, fast_rate}, (m % 2) ? 16'h00ff : 16'h00ef);
    end
  endtask : t_uart

  // Pin held for 24 sampled edges, register read back while still held
  task t_rst;
    wr(8'h32);
    @(posedge clk);
    rst_pin <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ccs_pkg::SFR_CLOCK_SPEED_CONTROL, 8'h00, 1'b1);
    chk({15'h0000, sys_rst}, 16'h0001);
    repeat (19) @(posedge clk);
    rst_pin <= 1'b0;
    #1;
    chk({12'h000, rst_cause}, 16'h0001);
    @(posedge clk);
    #1;
    chk({15'h0000, sys_rst}, 16'h0001);
    repeat (4) @(posedge clk);
    rd(ccs_pkg::SFR_CLOCK_SPEED_CONTROL, 8'h00, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wr(8'h0e);
      @(posedge clk);
      int_rst_req <= 3'(1 << i);
      @(posedge clk);
      int_rst_req <= '0;
      #1;
      chk({12'h000, rst_cause}, 16'(2 << i));
      wr(8'h55);
      #1;
      chk({15'h0000, sys_rst}, 16'h0001);
      repeat (30) @(posedge clk);
      rd(ccs_pkg::SFR_CLOCK_SPEED_CONTROL, 8'h00, 1'b1);
      chk({15'h0000, sys_rst}, 16'h0000);
    end
  endtask : t_rst

  // ========================================================
  // Main sequence and watchdog
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    rst_b = 1'b0;
    rst_pin = 1'b0;
    int_rst_req = '0;
    uart_mode = 2'h0;
    sfr_req = '0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset;
    t_regs;
    t_speeds;
    t_uart;
    t_rst;
    end_sim;
  end

  // Far beyond the few hundred cycles the run needs
  initial begin
    #(40 * 20000);
    error_cnt++;
    end_sim;
  end
endmodule : testbench
